// [src/lpp_pkg.sv]
// Constants shared by the line printer parallel port
package lpp_pkg;

	// ***************************************************
	// Register map (APB byte addresses)
	// ***************************************************
	localparam logic [11:0] ADDR_CTRL = 12'h000;
	localparam logic [11:0] ADDR_STATUS = 12'h004;
	localparam logic [11:0] ADDR_VFS = 12'h008;

	// ***************************************************
	// Control register fields
	// ***************************************************
	localparam int CTRL_LEN136_BIT = 0;
	localparam int CTRL_IGN8_BIT = 1;
	localparam int CTRL_PAR_LSB = 2;
	localparam int CTRL_ACTLOW_BIT = 4;
	localparam int CTRL_FORCE0_BIT = 5;
	localparam int CTRL_PAGE_LSB = 8;
	localparam logic CTRL_LEN136_RST = 1'b1;
	localparam logic [7:0] PAGE_LEN_RST = 8'h42;

	// ***************************************************
	// Status register fields
	// ***************************************************
	localparam int STAT_READY_BIT = 0;
	localparam int STAT_ONLINE_BIT = 1;
	localparam int STAT_PFAULT_BIT = 2;
	localparam int STAT_MOVE_BIT = 3;
	localparam int STAT_STATE_LSB = 4;
	localparam int STAT_CNT_LSB = 8;
	localparam int STAT_POS_LSB = 16;

	// ***************************************************
	// Parity modes, codes, line lengths
	// ***************************************************
	localparam logic [1:0] PAR_EVEN = 2'h0;
	localparam logic [1:0] PAR_ODD = 2'h1;
	localparam logic [1:0] PAR_NONE = 2'h2;
	localparam logic [7:0] CODE_LF = 8'h0A;
	localparam logic [7:0] CODE_FF = 8'h0C;
	localparam logic [7:0] CODE_CR = 8'h0D;
	localparam logic [7:0] CODE_SPACE = 8'h20;
	localparam logic [7:0] LEN_SHORT = 8'h84;
	localparam logic [7:0] LEN_LONG = 8'h88;
	localparam int STORE_DEPTH = 136;

	// ***************************************************
	// Timing
	// ***************************************************
	localparam int CLK_HZ = 10000000;
	localparam int EARLY_MS = 14;
	localparam int EARLY_CYC = EARLY_MS * (CLK_HZ / 1000);
	localparam int FEED_LINE_MS = 20;
	localparam int FEED_LINE_CYC = FEED_LINE_MS * (CLK_HZ / 1000);

	typedef enum logic [1:0] {
		LPP_IDLE = 2'h0,
		LPP_PRINT = 2'h1,
		LPP_FEED = 2'h3
	} lpp_state_e;

endpackage

// [src/lpp_top.sv]
// Printer-side parallel byte port with line store, print sequencing and APB registers
//
// The APB interface to the registers and the register addresses are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none

module lpp_top #(
	parameter int EARLY_CYC = lpp_pkg::EARLY_CYC,
	parameter int FEED_LINE_CYC = lpp_pkg::FEED_LINE_CYC
) (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic ce,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Host pins
	input wire logic byte_strobe,
	input wire logic [7:0] host_data_lines,
	input wire logic host_data_parity,
	input wire logic forms_control_flag,
	input wire logic line_buffer_flush,
	output logic byte_request,
	output logic machine_ready_ok,
	output logic online_out,
	output logic parity_fault_out,
	output logic paper_moving_out,
	output logic page_first_line_out,
	output logic page_last_line_out,
	output logic [1:0] band_type_out,
	// Mechanism status, same clock domain
	input wire logic mech_supply_ok,
	input wire logic mech_unit_closed,
	input wire logic mech_forms_end,
	input wire logic mech_init_done,
	input wire logic mech_hammer_ok,
	input wire logic mech_error,
	input wire logic mech_band_rotating,
	input wire logic [1:0] mech_band_type,
	input wire logic op_start_press,
	input wire logic op_stop_press,
	// Column stream to the hammer driver
	output logic prn_valid,
	output logic [7:0] prn_col,
	output logic [7:0] prn_data
);

	initial begin
		if (EARLY_CYC < 1 || FEED_LINE_CYC < 1) begin
			$error("lpp_top: timing counts must be at least one cycle");
		end
	end

	localparam int PW = 12;

	// ***************************************************
	// State
	// ***************************************************
	typedef struct packed {
		logic [PW-1:0] s1;
		logic [PW-1:0] s2;
		logic [PW-1:0] s3;
		logic [PW-1:0] filt;
		logic stb_d;
		lpp_pkg::lpp_state_e st;
		logic [7:0] cnt;
		logic [lpp_pkg::STORE_DEPTH-1:0][7:0] store;
		logic [7:0] col;
		logic [31:0] feed_left;
		logic [7:0] lines;
		logic [7:0] pos;
		logic pend;
		logic [7:0] pend_lines;
		logic [7:0] vfs;
		logic pfault;
		logic run_latch;
		logic req;
		logic len136;
		logic ign8;
		logic [1:0] par_mode;
		logic act_low;
		logic force0;
		logic [7:0] page_len;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
		logic o_req;
		logic o_ready;
		logic o_online;
		logic o_wchk;
		logic o_move;
		logic o_first;
		logic o_last;
		logic [1:0] o_band;
		logic prn_valid;
		logic [7:0] prn_col;
		logic [7:0] prn_data;
	} lpp_state_s;

	lpp_state_s q_r;
	lpp_state_s q_nxt;

	// Lines to feed for a terminating byte
	function automatic logic [7:0] lpp_feed_lines(
		input logic fc,
		input logic [7:0] code,
		input logic [7:0] pos,
		input logic [7:0] plen
	);
		logic [7:0] n;
		n = 8'h00;
		if (fc) begin
			// Skip command goes to top of page; space command holds a count
			if (code[7]) begin
				n = plen - pos;
			end else begin
				n = {4'h0, code[3:0]};
			end
		end else if (code == lpp_pkg::CODE_LF) begin
			n = 8'h01;
		end else if (code == lpp_pkg::CODE_FF) begin
			n = plen - pos;
		end
		return n;
	endfunction

	logic [PW-1:0] pins;
	logic [PW-1:0] lv;
	logic stb_lv;
	logic stb_edge;
	logic [7:0] dat;
	logic par_err;
	logic ready_c;
	logic online_c;
	logic [7:0] len_c;
	logic is_term;
	logic [7:0] term_lines;
	logic [8:0] pos_sum;
	logic feed_done;
	logic window_c;
	logic apb_setup;
	logic apb_wr;
	logic [31:0] ctrl_v;
	logic [31:0] stat_v;
	logic pfault_clr;

	assign pins = {line_buffer_flush, byte_strobe, forms_control_flag, host_data_parity,
		host_data_lines};

	always_comb begin
		q_nxt = q_r;
		// Three stage pin synchroniser; stage one only feeds stage two
		q_nxt.s1 = pins;
		q_nxt.s2 = q_r.s1;
		q_nxt.s3 = q_r.s2;
		for (int i = 0; i < PW; i++) begin
			if (q_r.s2[i] == q_r.s3[i]) begin
				q_nxt.filt[i] = q_r.s3[i];
			end
		end
		lv = q_r.filt ^ {PW{q_r.act_low}};
		stb_lv = lv[10];
		q_nxt.stb_d = stb_lv;
		// Data and flags come from the same filtered sample as the strobe
		stb_edge = stb_lv & ~q_r.stb_d & q_r.req;
		dat = q_r.ign8 ? {1'b0, lv[6:0]} : lv[7:0];
		par_err = 1'b0;
		if (q_r.par_mode == lpp_pkg::PAR_EVEN) begin
			par_err = ^{dat, lv[8]};
		end else if (q_r.par_mode == lpp_pkg::PAR_ODD) begin
			par_err = ~(^{dat, lv[8]});
		end

		ready_c = mech_supply_ok & mech_unit_closed & ~mech_forms_end & mech_init_done
			& mech_hammer_ok & ~mech_error;
		if (op_stop_press | ~ready_c) begin
			q_nxt.run_latch = 1'b0;
		end else if (op_start_press) begin
			q_nxt.run_latch = 1'b1;
		end
		online_c = ready_c & q_r.run_latch & mech_band_rotating;

		len_c = q_r.len136 ? lpp_pkg::LEN_LONG : lpp_pkg::LEN_SHORT;
		is_term = lv[9] | dat == lpp_pkg::CODE_LF | dat == lpp_pkg::CODE_FF
			| dat == lpp_pkg::CODE_CR;
		term_lines = lpp_feed_lines(lv[9], dat, q_r.pos, q_r.page_len);
		feed_done = q_r.st == lpp_pkg::LPP_FEED && q_r.feed_left == 32'h0;
		window_c = q_r.st == lpp_pkg::LPP_FEED && q_r.feed_left <= 32'(EARLY_CYC)
			&& !q_r.pend && !feed_done;

		// ***************************************************
		// APB slave
		// ***************************************************
		apb_setup = psel & ~penable;
		apb_wr = psel & penable & pwrite & q_r.pready;
		ctrl_v = 32'h0;
		ctrl_v[lpp_pkg::CTRL_LEN136_BIT] = q_r.len136;
		ctrl_v[lpp_pkg::CTRL_IGN8_BIT] = q_r.ign8;
		ctrl_v[lpp_pkg::CTRL_PAR_LSB +: 2] = q_r.par_mode;
		ctrl_v[lpp_pkg::CTRL_ACTLOW_BIT] = q_r.act_low;
		ctrl_v[lpp_pkg::CTRL_FORCE0_BIT] = q_r.force0;
		ctrl_v[lpp_pkg::CTRL_PAGE_LSB +: 8] = q_r.page_len;
		stat_v = 32'h0;
		stat_v[lpp_pkg::STAT_READY_BIT] = ready_c;
		stat_v[lpp_pkg::STAT_ONLINE_BIT] = online_c;
		stat_v[lpp_pkg::STAT_PFAULT_BIT] = q_r.pfault;
		stat_v[lpp_pkg::STAT_MOVE_BIT] = q_r.o_move ^ q_r.act_low;
		stat_v[lpp_pkg::STAT_STATE_LSB +: 2] = q_r.st;
		stat_v[lpp_pkg::STAT_CNT_LSB +: 8] = q_r.cnt;
		stat_v[lpp_pkg::STAT_POS_LSB +: 8] = q_r.pos;
		q_nxt.pready = apb_setup;
		if (apb_setup) begin
			q_nxt.pslverr = 1'b0;
			q_nxt.prdata = 32'h0;
			case (paddr)
				lpp_pkg::ADDR_CTRL: begin
					q_nxt.prdata = pwrite ? 32'h0 : ctrl_v;
				end
				lpp_pkg::ADDR_STATUS: begin
					q_nxt.prdata = pwrite ? 32'h0 : stat_v;
				end
				lpp_pkg::ADDR_VFS: begin
					q_nxt.prdata = pwrite ? 32'h0 : {24'h0, q_r.vfs};
				end
				default: begin
					q_nxt.pslverr = 1'b1;
				end
			endcase
		end else if (psel & penable & q_r.pready) begin
			q_nxt.prdata = 32'h0;
			q_nxt.pslverr = 1'b0;
		end
		pfault_clr = 1'b0;
		if (apb_wr && paddr == lpp_pkg::ADDR_CTRL) begin
			q_nxt.len136 = pwdata[lpp_pkg::CTRL_LEN136_BIT];
			q_nxt.ign8 = pwdata[lpp_pkg::CTRL_IGN8_BIT];
			q_nxt.par_mode = pwdata[lpp_pkg::CTRL_PAR_LSB +: 2];
			q_nxt.act_low = pwdata[lpp_pkg::CTRL_ACTLOW_BIT];
			q_nxt.force0 = pwdata[lpp_pkg::CTRL_FORCE0_BIT];
			q_nxt.page_len = pwdata[lpp_pkg::CTRL_PAGE_LSB +: 8];
		end
		if (apb_wr && paddr == lpp_pkg::ADDR_STATUS) begin
			pfault_clr = pwdata[lpp_pkg::STAT_PFAULT_BIT];
		end

		// ***************************************************
		// Byte intake
		// ***************************************************
		// Fault is sticky; a new error beats a clear in the same cycle
		if (stb_edge & par_err) begin
			q_nxt.pfault = 1'b1;
		end else if (pfault_clr) begin
			q_nxt.pfault = 1'b0;
		end
		q_nxt.prn_valid = 1'b0;
		pos_sum = 9'h0;
		if (stb_edge) begin
			if (lv[9]) begin
				q_nxt.vfs = dat;
			end
			if (is_term) begin
				if (q_r.st == lpp_pkg::LPP_FEED) begin
					// Held until the running feed is over
					q_nxt.pend = 1'b1;
					q_nxt.pend_lines = term_lines;
				end else if (q_r.cnt == 8'h00) begin
					q_nxt.st = lpp_pkg::LPP_FEED;
					q_nxt.lines = term_lines;
					q_nxt.feed_left = 32'(term_lines) * 32'(FEED_LINE_CYC);
				end else begin
					q_nxt.st = lpp_pkg::LPP_PRINT;
					q_nxt.lines = term_lines;
					q_nxt.col = 8'h00;
				end
			end else if (q_r.cnt < len_c) begin
				q_nxt.store[q_r.cnt] = dat;
				q_nxt.cnt = q_r.cnt + 8'h01;
			end // bytes past the length fall through here
		end

		// ***************************************************
		// Print and feed sequencing
		// ***************************************************
		case (q_r.st)
			lpp_pkg::LPP_IDLE: begin
			end
			lpp_pkg::LPP_PRINT: begin
				q_nxt.prn_valid = 1'b1;
				q_nxt.prn_col = q_r.col;
				q_nxt.prn_data = q_r.col < q_r.cnt ? q_r.store[q_r.col]
					: lpp_pkg::CODE_SPACE;
				q_nxt.col = q_r.col + 8'h01;
				if (q_r.col == len_c - 8'h01) begin
					q_nxt.st = lpp_pkg::LPP_FEED;
					q_nxt.cnt = 8'h00;
					q_nxt.feed_left = 32'(q_r.lines) * 32'(FEED_LINE_CYC);
				end
			end
			lpp_pkg::LPP_FEED: begin
				if (q_r.feed_left != 32'h0) begin
					q_nxt.feed_left = q_r.feed_left - 32'h1;
				end else begin
					pos_sum = {1'b0, q_r.pos} + {1'b0, q_r.lines};
					if (pos_sum >= {1'b0, q_r.page_len}) begin
						pos_sum = pos_sum - {1'b0, q_r.page_len};
					end
					q_nxt.pos = pos_sum[7:0];
					if (q_r.pend) begin
						q_nxt.pend = 1'b0;
						q_nxt.lines = q_r.pend_lines;
						if (q_r.cnt == 8'h00) begin
							q_nxt.feed_left = 32'(q_r.pend_lines) * 32'(FEED_LINE_CYC);
						end else begin
							q_nxt.st = lpp_pkg::LPP_PRINT;
							q_nxt.col = 8'h00;
						end
					end else begin
						q_nxt.st = lpp_pkg::LPP_IDLE;
					end
				end
			end
			default: begin
				q_nxt.st = lpp_pkg::LPP_IDLE;
			end
		endcase

		// Flush empties the store; a byte in the same cycle is lost with it
		if (lv[11]) begin
			q_nxt.cnt = 8'h00;
		end

		// ***************************************************
		// Interface outputs
		// ***************************************************
		q_nxt.req = ready_c & online_c & ~stb_lv & ~stb_edge
			& (q_r.st == lpp_pkg::LPP_IDLE | window_c) & ~(stb_edge & is_term);
		q_nxt.o_req = q_nxt.req ^ q_r.act_low;
		q_nxt.o_ready = ready_c ^ q_r.act_low;
		q_nxt.o_online = online_c ^ q_r.act_low;
		q_nxt.o_wchk = q_nxt.pfault ^ q_r.act_low;
		q_nxt.o_move = ((q_r.st == lpp_pkg::LPP_FEED && q_r.feed_left != 32'h0)
			& ~q_r.force0) ^ q_r.act_low;
		q_nxt.o_first = ((q_r.st == lpp_pkg::LPP_PRINT && q_r.pos == 8'h00)
			& ~q_r.force0) ^ q_r.act_low;
		q_nxt.o_last = ((q_r.st == lpp_pkg::LPP_PRINT && q_r.pos == q_r.page_len - 8'h01)
			& ~q_r.force0) ^ q_r.act_low;
		q_nxt.o_band = (mech_band_type & {2{~q_r.force0}}) ^ {2{q_r.act_low}};
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			q_r <= '0;
			q_r.st <= lpp_pkg::LPP_IDLE;
			q_r.len136 <= lpp_pkg::CTRL_LEN136_RST;
			q_r.par_mode <= lpp_pkg::PAR_EVEN;
			q_r.page_len <= lpp_pkg::PAGE_LEN_RST;
		end else if (ce) begin
			q_r <= q_nxt;
		end
	end

	assign prdata = q_r.prdata;
	assign pready = q_r.pready;
	assign pslverr = q_r.pslverr;
	assign byte_request = q_r.o_req;
	assign machine_ready_ok = q_r.o_ready;
	assign online_out = q_r.o_online;
	assign parity_fault_out = q_r.o_wchk;
	assign paper_moving_out = q_r.o_move;
	assign page_first_line_out = q_r.o_first;
	assign page_last_line_out = q_r.o_last;
	assign band_type_out = q_r.o_band;
	assign prn_valid = q_r.prn_valid;
	assign prn_col = q_r.prn_col;
	assign prn_data = q_r.prn_data;

endmodule

`default_nettype wire

// [tb/line_printer_parallel_port_test.sv]
// Self-checking bench for the line printer parallel port
`timescale 1ns/100ps
`default_nettype none
module line_printer_parallel_port_test;
	localparam int EC = 4;
	localparam int FC = 10;
	logic core_clk = 1'b0;
	logic rst_n = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready, pslverr, byte_strobe, host_data_parity, forms_control_flag, done;
	logic [7:0] host_data_lines, prn_col, prn_data;
	logic byte_request, machine_ready_ok, online_out, parity_fault_out, paper_moving_out;
	logic page_first_line_out, page_last_line_out, prn_valid;
	logic [1:0] band_type_out;
	logic [1:0] mech_band_type = 2'h0;
	logic line_buffer_flush = 1'b0;
	logic mech_error = 1'b0;
	logic mech_forms_end = 1'b0;
	logic op_stop_press = 1'b0;
	logic mech_band_rotating = 1'b1;
	logic op_start_press = 1'b0;
	logic go = 1'b0;
	logic tx_fc = 1'b0;
	logic tx_p = 1'b0;
	logic [7:0] tx_b = 8'h00;
	logic [7:0] pbuf [0:135];
	logic [7:0] eb [0:135];
	logic [31:0] pctl [5] = '{32'h4201, 32'h4205, 32'h4205, 32'h4209, 32'h4203};
	logic [7:0] pb [5] = '{8'h41, 8'h43, 8'h43, 8'h45, 8'hC5};
	logic [4:0] pbad = 5'h0D;
	logic [4:0] pexp = 5'h05;
	int cnt = 0;
	int mv = 0;
	int errors = 0;
	int n_tests = 0;
	always #50 core_clk = ~core_clk;
	lpp_host_model host (.core_clk(core_clk), .rst_n(rst_n), .go(go), .tx_b(tx_b),
		.tx_fc(tx_fc), .tx_p(tx_p), .byte_request(byte_request), .byte_strobe(byte_strobe),
		.host_data_lines(host_data_lines), .host_data_parity(host_data_parity),
		.forms_control_flag(forms_control_flag), .done(done));
	lpp_top #(.EARLY_CYC(EC), .FEED_LINE_CYC(FC)) uut (.core_clk(core_clk), .rst_n(rst_n),
		.ce(1'b1), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.byte_strobe(byte_strobe), .host_data_lines(host_data_lines),
		.host_data_parity(host_data_parity), .forms_control_flag(forms_control_flag),
		.line_buffer_flush(line_buffer_flush), .byte_request(byte_request),
		.machine_ready_ok(machine_ready_ok), .online_out(online_out),
		.parity_fault_out(parity_fault_out), .paper_moving_out(paper_moving_out),
		.page_first_line_out(page_first_line_out), .page_last_line_out(page_last_line_out),
		.band_type_out(band_type_out), .mech_supply_ok(1'b1), .mech_unit_closed(1'b1),
		.mech_forms_end(mech_forms_end), .mech_init_done(1'b1), .mech_hammer_ok(1'b1),
		.mech_error(mech_error), .mech_band_rotating(mech_band_rotating),
		.mech_band_type(mech_band_type), .op_start_press(op_start_press),
		.op_stop_press(op_stop_press), .prn_valid(prn_valid), .prn_col(prn_col),
		.prn_data(prn_data));
	// ****************************************
	// Column stream and feed monitor
	// ****************************************
	always @(posedge core_clk) begin
		if (prn_valid === 1'b1) begin
			pbuf[prn_col] <= prn_data;
			cnt <= cnt + 1;
		end
		if (paper_moving_out === 1'b1) mv <= mv + 1;
	end
	// ****************************************
	// Tasks
	// ****************************************
	function automatic logic fpar(input logic [7:0] b, input logic odd);
		return odd ? ~^b : ^b;
	endfunction
	task automatic complete_run();
		$display("tests %0d mismatches %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			errors++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		int n;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge core_clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n == 20) errors++;
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// Idle cycle so a following call never re-drives psel in this time step
		@(posedge core_clk);
	endtask
	task automatic send(input logic [7:0] b, input logic fc, input logic p);
		int n;
		tx_b <= b;
		tx_fc <= fc;
		tx_p <= p;
		go <= 1'b1;
		@(posedge core_clk);
		go <= 1'b0;
		n = 0;
		while (done !== 1'b1 && n < 500) begin
			@(posedge core_clk);
			n++;
		end
		if (n == 500) errors++;
	endtask
	// Request returns inside the early window, so the rest of the feed is fixed
	task automatic wait_print();
		int n;
		n = 0;
		while (byte_request !== 1'b1 && n < 3000) begin
			@(posedge core_clk);
			n++;
		end
		if (n == 3000) errors++;
		repeat (EC + 6) @(posedge core_clk);
	endtask
	task automatic press();
		op_start_press <= 1'b1;
		@(posedge core_clk);
		op_start_press <= 1'b0;
		repeat (4) @(posedge core_clk);
	endtask
	task automatic line(input logic [31:0] ctrl, input int nb, input int len);
		logic [31:0] r;
		logic e;
		apb(1'b1, lpp_pkg::ADDR_CTRL, ctrl, r, e);
		cnt = 0;
		mv = 0;
		for (int i = 0; i < nb; i++) begin
			eb[i] = 8'h21 + 8'($urandom_range(0, 90));
			send(eb[i], 1'b0, fpar(eb[i], 1'b0));
		end
		send(lpp_pkg::CODE_LF, 1'b0, fpar(lpp_pkg::CODE_LF, 1'b0));
		wait_print();
		chk(cnt, len);
		for (int i = 0; i < len; i++) begin
			chk({24'h0, pbuf[i]}, {24'h0, i < nb ? eb[i] : lpp_pkg::CODE_SPACE});
		end
		chk(mv, FC);
		$display("test line of %0d bytes done", nb);
	endtask
	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		#(30000 * 100);
		errors++;
		complete_run();
	end
	initial begin
		logic [31:0] r;
		logic e;
		void'($urandom(32'h787b));
		repeat (4) @(posedge core_clk);
		rst_n <= 1'b1;
		@(posedge core_clk);
		apb(1'b0, lpp_pkg::ADDR_CTRL, 32'h0, r, e);
		chk(r, 32'h0000_4201);
		apb(1'b0, 12'h0FC, 32'h0, r, e);
		chk({31'h0, e}, 32'h1);
		press();
		chk({30'h0, machine_ready_ok, online_out}, 32'h3);
		mech_forms_end <= 1'b1;
		repeat (4) @(posedge core_clk);
		chk({30'h0, machine_ready_ok, online_out}, 32'h0);
		mech_forms_end <= 1'b0;
		press();
		chk({30'h0, machine_ready_ok, online_out}, 32'h3);
		mech_error <= 1'b1;
		repeat (4) @(posedge core_clk);
		chk({29'h0, machine_ready_ok, online_out, byte_request}, 32'h0);
		mech_error <= 1'b0;
		mech_band_rotating <= 1'b0;
		press();
		chk({30'h0, machine_ready_ok, online_out}, 32'h2);
		mech_band_rotating <= 1'b1;
		press();
		op_stop_press <= 1'b1;
		repeat (4) @(posedge core_clk);
		chk({30'h0, machine_ready_ok, online_out}, 32'h2);
		op_stop_press <= 1'b0;
		press();
		chk({30'h0, machine_ready_ok, online_out}, 32'h3);
		for (int i = 0; i < 4; i++) begin
			mech_band_type <= 2'(i);
			repeat (4) @(posedge core_clk);
			chk({30'h0, band_type_out}, 32'(i));
		end
		$display("test status done");
		line(32'h4201, 3, 136);
		line(32'h4200, 134, 132);
		send(8'h41, 1'b0, fpar(8'h41, 1'b0));
		line_buffer_flush <= 1'b1;
		repeat (6) @(posedge core_clk);
		line_buffer_flush <= 1'b0;
		repeat (6) @(posedge core_clk);
		cnt = 0;
		mv = 0;
		send(lpp_pkg::CODE_LF, 1'b0, fpar(lpp_pkg::CODE_LF, 1'b0));
		wait_print();
		chk(cnt, 0);
		chk(mv, FC);
		send(8'h01, 1'b1, fpar(8'h01, 1'b0));
		wait_print();
		apb(1'b0, lpp_pkg::ADDR_VFS, 32'h0, r, e);
		chk(r, 32'h1);
		chk(cnt, 0);
		$display("test flush and forms done");
		for (int i = 0; i < 5; i++) begin
			apb(1'b1, lpp_pkg::ADDR_STATUS, 32'h4, r, e);
			apb(1'b1, lpp_pkg::ADDR_CTRL, pctl[i], r, e);
			send(pb[i], 1'b0, fpar(pb[i] & (pctl[i][1] ? 8'h7F : 8'hFF), pctl[i][2]) ^ pbad[i]);
			repeat (6) @(posedge core_clk);
			chk({31'h0, parity_fault_out}, {31'h0, pexp[i]});
		end
		apb(1'b1, lpp_pkg::ADDR_CTRL, 32'h4221, r, e);
		repeat (4) @(posedge core_clk);
		chk({27'h0, band_type_out, paper_moving_out, page_first_line_out, page_last_line_out},
			32'h0);
		$display("test parity and force done");
		complete_run();
	end
endmodule
`default_nettype wire

// [tb/lpp_checker.sv]
// Concurrent checks on the host pins, column stream and APB handshake
`timescale 1ns/100ps
`default_nettype none
module lpp_checker #(
	parameter int EARLY_CYC = 4,
	parameter int FEED_LINE_CYC = 10
) (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	input wire logic byte_strobe,
	input wire logic byte_request,
	input wire logic online_out,
	input wire logic machine_ready_ok,
	input wire logic mech_error,
	input wire logic mech_band_rotating,
	input wire logic paper_moving_out,
	input wire logic prn_valid,
	input wire logic [7:0] prn_col
);
	// ****************************************
	// Run length of the column stream
	// ****************************************
	logic [8:0] run_r;
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			run_r <= 9'h000;
		end else begin
			run_r <= prn_valid ? run_r + 9'h001 : 9'h000;
		end
	end
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rst_n);
	sequence s_setup;
		psel && !penable;
	endsequence
	sequence s_take;
		$rose(byte_strobe) && byte_request;
	endsequence
	// Filter delay is four flops (three synchroniser stages and the filter) plus the edge detect
	property p_req_drop;
		s_take |-> ##[1:7] !byte_request;
	endproperty
	a_apb_zero_wait: assert property (s_setup |=> pready) else $error("pready late");
	a_apb_one_cycle: assert property (pready |=> !pready) else $error("pready held");
	a_req_drop: assert property (p_req_drop) else $error("request kept after strobe");
	a_req_online: assert property (!online_out [*2] |-> !byte_request) else $error("req offline");
	a_ready_error: assert property (mech_error [*2] |-> !machine_ready_ok) else $error("ready on error");
	a_online_band: assert property (!mech_band_rotating [*2] |-> !online_out) else $error("online");
	a_col_start: assert property ($rose(prn_valid) |-> prn_col == 8'h00) else $error("first col");
	a_col_step: assert property (prn_valid && $past(prn_valid) |-> prn_col == $past(prn_col) + 8'h01)
		else $error("column skipped");
	a_run_max: assert property (run_r <= 9'h088) else $error("line too long");
	a_print_quiet: assert property (prn_valid |-> !paper_moving_out && !byte_request)
		else $error("feed or request during print");
endmodule
bind lpp_top lpp_checker #(.EARLY_CYC(EARLY_CYC), .FEED_LINE_CYC(FEED_LINE_CYC)) u_chk (
	.core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pready(pready),
	.byte_strobe(byte_strobe), .byte_request(byte_request), .online_out(online_out),
	.machine_ready_ok(machine_ready_ok), .mech_error(mech_error),
	.mech_band_rotating(mech_band_rotating), .paper_moving_out(paper_moving_out),
	.prn_valid(prn_valid), .prn_col(prn_col));
`default_nettype wire

// [tb/lpp_host_model.sv]
// Host controller model: one byte per go pulse, strobed once the request is high
`timescale 1ns/100ps
`default_nettype none
module lpp_host_model (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic go,
	input wire logic [7:0] tx_b,
	input wire logic tx_fc,
	input wire logic tx_p,
	input wire logic byte_request,
	output logic byte_strobe,
	output logic [7:0] host_data_lines,
	output logic host_data_parity,
	output logic forms_control_flag,
	output logic done
);
	// ****************************************
	// Strobe sequencer
	// ****************************************
	logic [1:0] st;
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			st <= 2'h0;
			byte_strobe <= 1'b0;
			host_data_lines <= 8'h00;
			host_data_parity <= 1'b0;
			forms_control_flag <= 1'b0;
			done <= 1'b0;
		end else begin
			done <= 1'b0;
			case (st)
				2'h0: if (go) st <= 2'h1;
				2'h1: if (byte_request) begin
					byte_strobe <= 1'b1;
					host_data_lines <= tx_b;
					host_data_parity <= tx_p;
					forms_control_flag <= tx_fc;
					st <= 2'h2;
				end
				default: if (!byte_request) begin
					// Released lines flip so stale data cannot pass as valid
					byte_strobe <= 1'b0;
					host_data_lines <= ~host_data_lines;
					host_data_parity <= ~host_data_parity;
					forms_control_flag <= ~forms_control_flag;
					done <= 1'b1;
					st <= 2'h0;
				end
			endcase
		end
	end
endmodule
`default_nettype wire
